//--- inc/uda_pkg.sv
// Purpose: shared constants and types of the command front end and data-out burst logic
// Assumes: 32-bit APB, word-aligned registers
// Notes: every offset, the status, control, event and drive/head field positions, the drive/head reset value and the pause cycle count live here
package uda_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_FEATURE  = 8'h00;
  localparam logic [7:0] OFS_SECCNT   = 8'h04;
  localparam logic [7:0] OFS_SECNUM   = 8'h08;
  localparam logic [7:0] OFS_CYL      = 8'h0C;
  localparam logic [7:0] OFS_DRVHEAD  = 8'h10;
  localparam logic [7:0] OFS_COMMAND  = 8'h14;
  localparam logic [7:0] OFS_STATUS   = 8'h18;
  localparam logic [7:0] OFS_CTRL     = 8'h1C;
  localparam logic [7:0] OFS_IRQ_STS  = 8'h20;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h24;
  localparam logic [7:0] OFS_DATA     = 8'h28;
  localparam logic [7:0] OFS_XFER     = 8'h2C;
  localparam logic [7:0] OFS_ADDR     = 8'h30;
  // status fields
  localparam int ST_ERR   = 0;
  localparam int ST_DRDY  = 6;
  localparam int ST_BSY   = 7;
  localparam int ST_CLS   = 8;
  localparam int ST_BURST = 10;
  // control fields
  localparam int CT_DONE  = 0;
  localparam int CT_GO    = 1;
  localparam int CT_INV   = 2;
  // interrupt events
  localparam int IRQ_N    = 4;
  localparam int EV_OK    = 0;
  localparam int EV_BAD   = 1;
  localparam int EV_WORD  = 2;
  localparam int EV_END   = 3;
  // drive/head fields
  localparam int DH_LBA   = 6;
  // drive/head reset value and the sector total for a zero count
  localparam logic [7:0] RST_DRVHEAD = 8'hA0;
  localparam logic [8:0] SEC_ZERO_MEANS = 9'h100;
  // timing: link pause-to-end least time, value arbitrary plain default
  localparam int CLK_MHZ  = 100;
  localparam int TRP_NS   = 160;
  localparam int TRP_CYC_RAW = (TRP_NS * CLK_MHZ + 999) / 1000;
  localparam int TRP_CYC  = (TRP_CYC_RAW < 1) ? 1 : TRP_CYC_RAW;
  localparam int PAUSE_ROOM = 3;

  typedef enum logic [1:0] {
    CLS_NONDATA = 2'b00,
    CLS_DATA_IN = 2'b01,
    CLS_DATA_OUT = 2'b10,
    CLS_INVALID = 2'b11
  } uda_cls_t;

  typedef enum logic [2:0] {
    B_IDLE  = 3'b000,
    B_REQ   = 3'b001,
    B_XFER  = 3'b010,
    B_PAUSE = 3'b011,
    B_END   = 3'b100
  } uda_bst_t;

  typedef struct packed {
    logic [7:0]  feat;
    logic [7:0]  scnt;
    logic [7:0]  snum;
    logic [15:0] cyl;
    logic [7:0]  dh;
  } uda_taskfile_t;
endpackage : uda_pkg

//--- verilog/uda_sync.sv
// Purpose: two-flop synchroniser for a bundle of pin levels
// Assumes: each bit is a level or a slow strobe
// Notes: first stage feeds only the second stage
`timescale 1ns/1ps
`default_nettype none
module uda_sync #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // levels
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_q;

  // two stages, reset to zero
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= '0;
      q      <= '0;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule : uda_sync
`default_nettype wire

//--- verilog/uda_wmem.sv
// Purpose: small word store for captured host data
// Assumes: one write and one read port on one clock
// Notes: read data comes out of a register, one edge after the address
`timescale 1ns/1ps
`default_nettype none
module uda_wmem #(
  parameter int W = 16,
  parameter int D = 8,
  parameter int AW = $clog2(D)
) (
  // clock
  input  wire logic          clk,
  // write port
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [W-1:0]  wdata,
  // read port
  input  wire logic [AW-1:0] raddr,
  output logic      [W-1:0]  rdata
);
  logic [W-1:0] mem [D];

  // storage has no reset; contents are only read after a write
  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule : uda_wmem
`default_nettype wire

//--- verilog/uda_core.sv
// Purpose: task-file command front end with data-out burst flow control
// Assumes: APB master acts for the host; link pins sampled by pclk
// Notes:
// Operation
// - a device-ended burst drops the request only after the pause time since ready fell; a host stop ends it at once
// - after ready falls, up to three more strobed words are still taken
// - with request and acknowledge both off, ready stops being driven
// - request and acknowledge polarity is chosen by the interface mode bit
// - writing the command snapshots the loaded parameters and starts processing
// - each accepted command falls into one of three classes
// - every listed code is decoded and accepted, possibly as a no-op
// - an unknown code reports an invalid-command error, nothing executes
// - security codes F1 to F6 other than F5 are left unimplemented
// - code CDh takes full task-file parameters with block addressing
// - code 38h takes full task-file parameters with block addressing
// - sector count zero means 256 sectors
// - head number is the low four bits of drive/head, 0 to 15
`timescale 1ns/1ps
`default_nettype none
module uda_core #(
  parameter int DEPTH   = 8,
  parameter int TRP_CYC = uda_pkg::TRP_CYC
) (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic             pslverr,
  output logic      [31:0] prdata,
  // interrupt
  output logic             irq,
  // data-out link pins
  input  wire logic [15:0] hd_i,
  input  wire logic        hstrobe_i,
  input  wire logic        stop_i,
  input  wire logic        dmack_i,
  output logic             dmarq_o,
  output logic             ddmardy_n_o,
  output logic             ddmardy_oe
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] CNT_PAUSE = (AW+1)'(DEPTH - uda_pkg::PAUSE_ROOM);
  localparam logic [AW:0] CNT_FULL  = (AW+1)'(DEPTH);
  localparam logic [7:0]  TRP_MAX   = 8'(TRP_CYC);

  // command class decode, used by the register path and the interrupt events
  function automatic uda_pkg::uda_cls_t cls_of(input logic [7:0] c);
    case (c) inside
      8'hEC, 8'hE4, 8'hC4, 8'h20, 8'h21, 8'hC8:                    cls_of = uda_pkg::CLS_DATA_IN;
      8'h50, 8'hE8, 8'hC5, 8'hCD, 8'h30, 8'h31, 8'h38, 8'h3C, 8'hCA: cls_of = uda_pkg::CLS_DATA_OUT;
      8'hE5, 8'h98, 8'h90, 8'hC0, 8'hE3, 8'h97, 8'hE1, 8'h95, 8'h91, 8'h00, 8'h40, 8'h41,
      8'h03, 8'hEF, 8'hC6, 8'hE6, 8'h99, 8'hE2, 8'h96, 8'hE0, 8'h94, 8'h87, 8'hF5,
      8'b0001_????, 8'b0111_????:                                    cls_of = uda_pkg::CLS_NONDATA;
      default:                                                       cls_of = uda_pkg::CLS_INVALID;
    endcase
  endfunction : cls_of

  // link pins through two flops
  logic [15:0] hd_s;
  logic        stb_s;
  logic        stop_s;
  logic        ack_s;
  uda_sync #(.W(19)) u_sync (
    .clk   (pclk),
    .rst_n (presetn),
    .d     ({hd_i, hstrobe_i, stop_i, dmack_i}),
    .q     ({hd_s, stb_s, stop_s, ack_s})
  );

  // registers
  uda_pkg::uda_taskfile_t tf_q;
  uda_pkg::uda_taskfile_t snap_q;
  uda_pkg::uda_cls_t      cls_q;
  uda_pkg::uda_bst_t      bst_q;
  logic [7:0]         cmd_q;
  logic               busy_q;
  logic               err_q;
  logic               rej_q;
  logic               go_q;
  logic               inv_q;
  logic [3:0]         irq_sts_q;
  logic [3:0]         irq_mask_q;
  logic [31:0]        prdata_q;
  logic               stb_q;
  logic [AW-1:0]      wr_ptr_q;
  logic [AW-1:0]      rd_ptr_q;
  logic [AW-1:0]      rd_ptr_d;
  logic [AW:0]        cnt_q;
  logic [7:0]         trp_q;
  logic [15:0]        mem_rdata;

  // bus decode
  logic wr_acc;
  logic rd_acc;
  logic setup;
  logic mapped;
  logic cmd_wr;
  logic done_wr;
  logic pop;
  logic push;
  logic stb_edge;
  logic ack_act;
  logic rq_act;
  logic rdy_act;
  logic [3:0] ev;
  logic [8:0] sec_total;

  assign setup   = psel & ~penable;
  assign wr_acc  = psel & penable & pwrite;
  assign rd_acc  = psel & penable & ~pwrite;
  assign mapped  = (paddr <= uda_pkg::OFS_ADDR) && (paddr[1:0] == 2'b00);
  assign cmd_wr  = wr_acc && paddr == uda_pkg::OFS_COMMAND && !busy_q;
  assign done_wr = wr_acc && paddr == uda_pkg::OFS_CTRL && pwdata[uda_pkg::CT_DONE];
  assign pop     = rd_acc && paddr == uda_pkg::OFS_DATA && cnt_q != '0;
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~mapped;
  assign prdata  = prdata_q;
  assign irq     = |(irq_sts_q & irq_mask_q);

  // task-file parameter registers, loaded before the command
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tf_q    <= '0;
      tf_q.dh <= uda_pkg::RST_DRVHEAD;
    end else if (wr_acc && !busy_q) begin
      case (paddr)
        uda_pkg::OFS_FEATURE: tf_q.feat <= pwdata[7:0];
        uda_pkg::OFS_SECCNT:  tf_q.scnt <= pwdata[7:0];
        uda_pkg::OFS_SECNUM:  tf_q.snum <= pwdata[7:0];
        uda_pkg::OFS_CYL:     tf_q.cyl  <= pwdata[15:0];
        uda_pkg::OFS_DRVHEAD: tf_q.dh   <= pwdata[7:0];
        default: ;
      endcase
    end
  end

  // command write: snapshot, classify, busy until done or rejected
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      snap_q <= '0;
      cmd_q  <= '0;
      cls_q  <= uda_pkg::CLS_NONDATA;
      busy_q <= 1'b0;
      err_q  <= 1'b0;
      rej_q  <= 1'b0;
    end else if (cmd_wr) begin
      snap_q <= tf_q;
      cmd_q  <= pwdata[7:0];
      cls_q  <= cls_of(pwdata[7:0]);
      busy_q <= 1'b1;
      err_q  <= cls_of(pwdata[7:0]) == uda_pkg::CLS_INVALID;
      rej_q  <= cls_of(pwdata[7:0]) == uda_pkg::CLS_INVALID;
    end else if (rej_q || done_wr) begin
      busy_q <= 1'b0;
      rej_q  <= 1'b0;
    end
  end

  // sector total and addressing view of the snapshot
  assign sec_total = (snap_q.scnt == 8'h00) ? uda_pkg::SEC_ZERO_MEANS : {1'b0, snap_q.scnt};

  // control register: burst enable and bus polarity mode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      go_q  <= 1'b0;
      inv_q <= 1'b0;
    end else if (wr_acc && paddr == uda_pkg::OFS_CTRL) begin
      go_q  <= pwdata[uda_pkg::CT_GO];
      inv_q <= pwdata[uda_pkg::CT_INV];
    end
  end

  // sticky events, write one to clear; a new event beats the clear
  assign ev[uda_pkg::EV_OK]   = cmd_wr && cls_of(pwdata[7:0]) != uda_pkg::CLS_INVALID;
  assign ev[uda_pkg::EV_BAD]  = cmd_wr && cls_of(pwdata[7:0]) == uda_pkg::CLS_INVALID;
  assign ev[uda_pkg::EV_WORD] = push;
  assign ev[uda_pkg::EV_END]  = bst_q == uda_pkg::B_END && !ack_act;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_sts_q  <= '0;
      irq_mask_q <= '0;
    end else begin
      if (wr_acc && paddr == uda_pkg::OFS_IRQ_STS) begin
        irq_sts_q <= (irq_sts_q & ~pwdata[3:0]) | ev;
      end else begin
        irq_sts_q <= irq_sts_q | ev;
      end
      if (wr_acc && paddr == uda_pkg::OFS_IRQ_MASK) begin
        irq_mask_q <= pwdata[3:0];
      end
    end
  end

  // read data is registered in the setup phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= '0;
    end else if (setup) begin
      case (paddr)
        uda_pkg::OFS_FEATURE:  prdata_q <= {24'h0, tf_q.feat};
        uda_pkg::OFS_SECCNT:   prdata_q <= {24'h0, tf_q.scnt};
        uda_pkg::OFS_SECNUM:   prdata_q <= {24'h0, tf_q.snum};
        uda_pkg::OFS_CYL:      prdata_q <= {16'h0, tf_q.cyl};
        uda_pkg::OFS_DRVHEAD:  prdata_q <= {24'h0, tf_q.dh};
        uda_pkg::OFS_COMMAND:  prdata_q <= {24'h0, cmd_q};
        uda_pkg::OFS_STATUS:   prdata_q <= {21'h0, rq_act, cls_q, busy_q, ~busy_q, 5'h0, err_q};
        uda_pkg::OFS_CTRL:     prdata_q <= {29'h0, inv_q, go_q, 1'b0};
        uda_pkg::OFS_IRQ_STS:  prdata_q <= {28'h0, irq_sts_q};
        uda_pkg::OFS_IRQ_MASK: prdata_q <= {28'h0, irq_mask_q};
        uda_pkg::OFS_DATA:     prdata_q <= {15'h0, cnt_q != '0, mem_rdata};
        uda_pkg::OFS_XFER:     prdata_q <= {18'h0, snap_q.dh[uda_pkg::DH_LBA], snap_q.dh[3:0], sec_total};
        uda_pkg::OFS_ADDR:     prdata_q <= {4'h0, snap_q.dh[3:0], snap_q.cyl, snap_q.snum};
        default:               prdata_q <= '0;
      endcase
    end
  end

  // polarity per mode on request and acknowledge
  assign ack_act     = ack_s ^ inv_q;
  assign rq_act      = bst_q == uda_pkg::B_REQ || bst_q == uda_pkg::B_XFER || bst_q == uda_pkg::B_PAUSE;
  assign rdy_act     = bst_q == uda_pkg::B_XFER;
  assign dmarq_o     = rq_act ^ inv_q;
  assign ddmardy_n_o = ~rdy_act;
  assign ddmardy_oe  = rq_act | ack_act;

  // burst state: request, transfer, pause, end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bst_q <= uda_pkg::B_IDLE;
      trp_q <= '0;
    end else begin
      case (bst_q)
        uda_pkg::B_IDLE: begin
          if (go_q && cnt_q < CNT_PAUSE) begin
            bst_q <= uda_pkg::B_REQ;
          end
        end
        uda_pkg::B_REQ: begin
          if (ack_act) begin
            bst_q <= uda_pkg::B_XFER;
          end
        end
        uda_pkg::B_XFER: begin
          trp_q <= '0;
          if (stop_s) begin
            bst_q <= uda_pkg::B_END;
          end else if (!go_q || cnt_q >= CNT_PAUSE) begin
            bst_q <= uda_pkg::B_PAUSE;
          end
        end
        uda_pkg::B_PAUSE: begin
          if (trp_q < TRP_MAX) begin
            trp_q <= trp_q + 8'h01;
          end
          if (stop_s) begin
            bst_q <= uda_pkg::B_END;
          end else if (!go_q && trp_q >= TRP_MAX) begin
            bst_q <= uda_pkg::B_END;
          end else if (go_q && cnt_q < CNT_PAUSE) begin
            bst_q <= uda_pkg::B_XFER;
          end
        end
        uda_pkg::B_END: begin
          if (!ack_act) begin
            bst_q <= uda_pkg::B_IDLE;
          end
        end
        default: bst_q <= uda_pkg::B_IDLE;
      endcase
    end
  end

  // word capture on either strobe edge while the burst owns the lines
  assign stb_edge = stb_s ^ stb_q;
  assign push     = stb_edge && ack_act && cnt_q < CNT_FULL &&
                    (bst_q == uda_pkg::B_XFER || bst_q == uda_pkg::B_PAUSE);
  assign rd_ptr_d = pop ? rd_ptr_q + 1'b1 : rd_ptr_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stb_q    <= 1'b0;
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      cnt_q    <= '0;
    end else begin
      stb_q    <= stb_s;
      rd_ptr_q <= rd_ptr_d;
      if (push) begin
        wr_ptr_q <= wr_ptr_q + 1'b1;
      end
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  // read port follows the next pointer so data is ready by the next setup
  uda_wmem #(.W(16), .D(DEPTH)) u_mem (
    .clk   (pclk),
    .we    (push),
    .waddr (wr_ptr_q),
    .wdata (hd_s),
    .raddr (rd_ptr_d),
    .rdata (mem_rdata)
  );

  property p_end_after_trp;
    @(posedge pclk) disable iff (!presetn)
    (bst_q == uda_pkg::B_PAUSE && !stop_s ##1 bst_q == uda_pkg::B_END) |-> $past(trp_q) >= TRP_MAX;
  endproperty
  a_end_after_trp: assert property (p_end_after_trp) else $error("burst ended before pause time");

  property p_room;
    @(posedge pclk) disable iff (!presetn) rdy_act |-> ##1 cnt_q <= CNT_PAUSE;
  endproperty
  a_room: assert property (p_room) else $error("ready held with too little room");

  // checks the end-to-idle step itself, not just the output decode
  property p_release;
    @(posedge pclk) disable iff (!presetn)
    (bst_q == uda_pkg::B_END && !ack_act) |=> bst_q == uda_pkg::B_IDLE && !ddmardy_oe && dmarq_o == inv_q;
  endproperty
  a_release: assert property (p_release) else $error("ready driven outside burst");

  property p_busy;
    @(posedge pclk) disable iff (!presetn) cmd_wr |-> ##1 busy_q && snap_q == $past(tf_q);
  endproperty
  a_busy: assert property (p_busy) else $error("command write did not set busy");

  property p_reject;
    @(posedge pclk) disable iff (!presetn)
    (cmd_wr && pwdata[7:0] == 8'hF1) |-> ##1 err_q ##1 !busy_q && irq_sts_q[uda_pkg::EV_BAD];
  endproperty
  a_reject: assert property (p_reject) else $error("security code not rejected");

  property p_wne;
    @(posedge pclk) disable iff (!presetn)
    (cmd_wr && (pwdata[7:0] == 8'hCD || pwdata[7:0] == 8'h38)) |-> ##1 !err_q && busy_q && cls_q == uda_pkg::CLS_DATA_OUT;
  endproperty
  a_wne: assert property (p_wne) else $error("write without erase refused");

  property p_count256;
    @(posedge pclk) disable iff (!presetn) (cmd_wr && tf_q.scnt == 8'h00) |-> ##1 sec_total == 9'h100;
  endproperty
  a_count256: assert property (p_count256) else $error("zero count not 256");

  property p_strobe_only;
    @(posedge pclk) disable iff (!presetn) $changed(cnt_q) && !$past(pop) |-> $past(stb_edge);
  endproperty
  a_strobe_only: assert property (p_strobe_only) else $error("word taken without strobe edge");
endmodule : uda_core
`default_nettype wire

//--- dv/uda_host_model.sv
// Purpose: behavioural host on the data-out link: acknowledges, strobes words, may stop
// Assumes: strobe edge every 80 ns inside a burst until three words pass with ready off, still outside it
// Notes: word n of a burst is A5 in the high byte and n in the low byte
`timescale 1ns/1ps
`default_nettype none
module uda_host_model (
  // mode and device pins
  input  wire logic       inv,
  input  wire logic       dmarq,
  input  wire logic       ddmardy_n,
  input  wire logic [3:0] stop_after,
  // host pins
  output logic      [15:0] hd,
  output logic             hstrobe,
  output logic             stop,
  output logic             dmack,
  output int               nsent
);
  logic ack_on;
  int   extra;

  assign dmack = ack_on ^ inv;

  // one burst per request; data set half a period before its strobe edge
  initial begin
    ack_on = 1'b0;
    hstrobe = 1'b0;
    stop = 1'b0;
    hd = 16'h0000;
    nsent = 0;
    forever begin
      // a polarity switch can fake a request for a moment, so it must still stand
      do begin
        wait (dmarq ^ inv);
        #202;
      end while (!(dmarq ^ inv));
      ack_on = 1'b1;
      nsent = 0;
      extra = 0;
      while ((dmarq ^ inv) && !stop) begin
        if (ddmardy_n === 1'b0) extra = 0;
        if (extra < 3) begin
          hd = {8'hA5, nsent[7:0]};
          #40 hstrobe = ~hstrobe;
          nsent++;
          if (ddmardy_n !== 1'b0) extra++;
        end
        #40;
        if (stop_after != 4'h0 && nsent == int'(stop_after)) stop = 1'b1;
      end
      wait (!(dmarq ^ inv));
      #102 ack_on = 1'b0;
      stop = 1'b0;
      hd = ~hd;
    end
  end
endmodule : uda_host_model
`default_nettype wire

//--- dv/uda_core_test.sv
// Purpose: self-checking bench for the command front end and data-out bursts
// Assumes: APB master in this module, host model on the link
// Notes: all checks are taken at the falling edge, where outputs have settled
`timescale 1ns/1ps
`default_nettype none
module uda_core_test;
  localparam int TRP = 40;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, se;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, r;
  logic [15:0] hd;
  logic        hstrobe, stop, dmack, dmarq_o, ddmardy_n_o, ddmardy_oe, inv;
  logic [3:0]  stop_after;
  int          nsent, errors, comparisons, cycles, rdy_hi, i, k;
  logic [7:0]  codes [17] = '{8'h00, 8'h90, 8'hC0, 8'hCD, 8'h38, 8'hCA, 8'hF5, 8'hE5, 8'hC8,
                              8'h1F, 8'h7A, 8'hF1, 8'hF2, 8'hF3, 8'hF4, 8'hF6, 8'h01};

  uda_core #(.DEPTH(8), .TRP_CYC(TRP)) u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .pslverr(pslverr), .prdata(prdata), .irq(irq), .hd_i(hd), .hstrobe_i(hstrobe), .stop_i(stop),
    .dmack_i(dmack), .dmarq_o(dmarq_o), .ddmardy_n_o(ddmardy_n_o), .ddmardy_oe(ddmardy_oe));

  uda_host_model u_host (.inv(inv), .dmarq(dmarq_o), .ddmardy_n(ddmardy_n_o), .stop_after(stop_after),
    .hd(hd), .hstrobe(hstrobe), .stop(stop), .dmack(dmack), .nsent(nsent));

  // clock
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // hang guard and count of cycles with ready deasserted
  always @(posedge pclk) begin
    rdy_hi <= (ddmardy_n_o === 1'b1) ? rdy_hi + 1 : 0;
    cycles <= cycles + 1;
    if (cycles == 50000) begin
      errors++;
      print_verdict();
    end
  end

  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e) begin
      errors++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask : chk

  // one APB transfer; waits for pready, leaves at the next falling edge
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    se = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(negedge pclk);
  endtask : apb

  // read n words back in arrival order, then expect an empty store
  task drain(input int n);
    int j;
    for (j = 0; j < n; j++) begin
      apb(1'b0, uda_pkg::OFS_DATA, 32'h0);
      chk("word", r[16:0], {1'b1, 8'hA5, 8'(j)});
    end
    apb(1'b0, uda_pkg::OFS_DATA, 32'h0);
    chk("empty", r[16], 1'b0);
  endtask : drain

  task t_reset;
    apb(1'b0, uda_pkg::OFS_DRVHEAD, 32'h0);
    chk("drvhead", r, 32'h000000A0);
    apb(1'b0, 8'h34, 32'h0);
    chk("unmapped", {se, r}, {1'b1, 32'h0});
    chk("rst pins", {irq, dmarq_o, ddmardy_oe}, 3'b000);
  endtask : t_reset

  task t_cmd(input logic [7:0] c, input logic bad);
    apb(1'b0, uda_pkg::OFS_STATUS, 32'h0);
    chk("free", r[uda_pkg::ST_BSY], 1'b0);
    apb(1'b1, uda_pkg::OFS_SECCNT, 32'h0);
    apb(1'b1, uda_pkg::OFS_SECNUM, 32'h5A);
    apb(1'b1, uda_pkg::OFS_CYL, 32'h1234);
    apb(1'b1, uda_pkg::OFS_DRVHEAD, 32'h4B);
    apb(1'b1, uda_pkg::OFS_COMMAND, {24'h0, c});
    apb(1'b0, uda_pkg::OFS_STATUS, 32'h0);
    if (!bad) chk("bsy", r[uda_pkg::ST_BSY], 1'b1);
    chk("err", r[uda_pkg::ST_ERR], bad);
    chk("cls", r[9:8] == 2'b11, bad);
    if (!bad) apb(1'b1, uda_pkg::OFS_COMMAND, 32'hF1); // dropped while busy
    apb(1'b0, uda_pkg::OFS_IRQ_STS, 32'h0);
    chk("ev", r[1:0], bad ? 2'b10 : 2'b01);
    chk("irq", irq, 1'b1);
    apb(1'b1, uda_pkg::OFS_IRQ_STS, 32'h3);
    chk("irq clr", irq, 1'b0);
    if (!bad) begin
      apb(1'b0, uda_pkg::OFS_XFER, 32'h0);
      if (c == 8'hCD || c == 8'h38) chk("xfer", r[13:0], {1'b1, 4'hB, 9'h100});
      apb(1'b0, uda_pkg::OFS_ADDR, 32'h0);
      chk("addr", r, 32'h0B12345A);
      apb(1'b1, uda_pkg::OFS_CTRL, 32'h1);
      apb(1'b0, uda_pkg::OFS_STATUS, 32'h0);
      chk("idle", r[uda_pkg::ST_BSY], 1'b0);
    end
  endtask : t_cmd

  // device pause by go=0: extra words still taken, request drops late
  task t_pause;
    apb(1'b1, uda_pkg::OFS_CTRL, 32'h2);
    for (i = 0; i < 400 && ddmardy_n_o !== 1'b0; i++) @(negedge pclk);
    chk("burst", {dmarq_o, ddmardy_oe}, 2'b11);
    for (i = 0; i < 400 && nsent < 2; i++) @(negedge pclk);
    apb(1'b1, uda_pkg::OFS_CTRL, 32'h0);
    for (i = 0; i < 400 && dmarq_o !== 1'b0; i++) @(negedge pclk);
    chk("end wait", rdy_hi >= TRP, 1'b1);
    chk("extra", nsent >= 5, 1'b1);
    for (i = 0; i < 400 && ddmardy_oe !== 1'b0; i++) @(negedge pclk);
    chk("released", ddmardy_oe, 1'b0);
    drain(nsent);
    apb(1'b0, uda_pkg::OFS_IRQ_STS, 32'h0);
    chk("burst ev", r[3:2], 2'b11);
    apb(1'b1, uda_pkg::OFS_IRQ_STS, 32'hF);
  endtask : t_pause

  // host stop in inverted polarity
  task t_stop;
    stop_after <= 4'h2;
    apb(1'b1, uda_pkg::OFS_CTRL, 32'h4);
    inv <= 1'b1;
    repeat (4) @(negedge pclk);
    chk("rq off", dmarq_o, 1'b1);
    apb(1'b1, uda_pkg::OFS_CTRL, 32'h6);
    for (i = 0; i < 400 && ddmardy_n_o !== 1'b0; i++) @(negedge pclk);
    chk("rq on", dmarq_o, 1'b0);
    for (i = 0; i < 400 && dmarq_o !== 1'b1; i++) @(negedge pclk);
    chk("stopped", dmarq_o, 1'b1);
    // drop go so the block does not open a second burst behind the checks
    apb(1'b1, uda_pkg::OFS_CTRL, 32'h4);
    for (i = 0; i < 400 && ddmardy_oe !== 1'b0; i++) @(negedge pclk);
    chk("released", ddmardy_oe, 1'b0);
    chk("sent", nsent, 2);
    drain(2);
  endtask : t_stop

  task print_verdict;
    if (errors == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : print_verdict

  // main sequence
  initial begin
    presetn = 1'b0;
    {psel, penable, pwrite, inv} = 4'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    stop_after = 4'h0;
    {errors, comparisons, cycles, rdy_hi} = 0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(negedge pclk);
    t_reset();
    apb(1'b1, uda_pkg::OFS_IRQ_MASK, 32'h3);
    for (k = 0; k < 17; k++) t_cmd(codes[k], k >= 11);
    apb(1'b1, uda_pkg::OFS_IRQ_MASK, 32'h0);
    apb(1'b1, uda_pkg::OFS_COMMAND, 32'h01);
    chk("masked", irq, 1'b0);
    apb(1'b1, uda_pkg::OFS_IRQ_STS, 32'hF);
    t_pause();
    t_stop();
    print_verdict();
  end
endmodule : uda_core_test
`default_nettype wire
